// ==== rtl/trace_trigger.sv ====
`timescale 1ns/1ps
`default_nettype none
module trace_trigger (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Target bus pins
    input wire logic [19:0] tgt_addr_i,
    input wire logic [15:0] tgt_data_i,
    input wire logic tgt_rd_n_i,
    input wire logic tgt_wr_n_i,
    // Events
    output logic irq_o,
    output logic trigger_o
);
    import trace_trigger_pkg::*;

    localparam int PW = $clog2(TRACE_DEPTH);
    localparam logic [PW-1:0] LAST_IDX = PW'(TRACE_DEPTH - 1);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    bus_cycle_s pin_s1;
    bus_cycle_s pin_s2;
    bus_cycle_s pin_s3;
    logic [1:0] strb_s1;
    logic [1:0] strb_s2;
    logic [1:0] strb_s3;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            strb_s1 <= 2'h3;
            strb_s2 <= 2'h3;
            strb_s3 <= 2'h3;
        end else begin
            pin_s1 <= '{~tgt_wr_n_i, tgt_addr_i, tgt_data_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            strb_s1 <= {tgt_wr_n_i, tgt_rd_n_i};
            strb_s2 <= strb_s1;
            strb_s3 <= strb_s2;
        end
    end

    // Cycle ends on strobe release; stage 3 still holds the valid bus
    logic cyc_pulse;
    bus_cycle_s cyc;
    assign cyc_pulse = |(strb_s2 & ~strb_s3);
    assign cyc = '{~strb_s3[1], pin_s3.addr, pin_s3.data};

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic wide_bus;
    logic cyc_en;
    logic restart;
    logic [15:0] delay_cfg;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [19:0] cyc_start;
    logic [19:0] cyc_stop;
    logic [PW-1:0] trace_index;
    cmp_s term_lo [N_TERMS];
    cmp_s term_hi [N_TERMS];

    logic wr_en;
    logic rd_en;
    assign wr_en = avs_write_i && !avs_waitrequest_o;
    assign rd_en = avs_read_i && avs_waitrequest_o;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // One wait state on every access; answer on the following edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i)
                                   && avs_waitrequest_o);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wide_bus <= 1'b0;
            cyc_en <= 1'b0;
            restart <= 1'b0;
            delay_cfg <= DELAY_RESET;
            irq_mask <= '0;
            cyc_start <= '0;
            cyc_stop <= '0;
            trace_index <= '0;
        end else begin
            restart <= 1'b0;
            if (wr_en) begin
                unique case (avs_address_i)
                    OFS_CONTROL: begin
                        if (avs_byteenable_i[0]) begin
                            restart <= avs_writedata_i[CTRL_START_BIT];
                            wide_bus <= avs_writedata_i[CTRL_WIDE_BIT];
                            cyc_en <= avs_writedata_i[CTRL_CYC_EN_BIT];
                        end
                    end
                    OFS_DELAY: begin
                        delay_cfg <= 16'(merge({16'h0000, delay_cfg},
                            avs_writedata_i, avs_byteenable_i));
                    end
                    OFS_IRQ_MASK: begin
                        if (avs_byteenable_i[0]) begin
                            irq_mask <= avs_writedata_i[IRQ_W-1:0];
                        end
                    end
                    OFS_CYC_START: begin
                        cyc_start <= 20'(merge({12'h000, cyc_start},
                            avs_writedata_i, avs_byteenable_i));
                    end
                    OFS_CYC_STOP: begin
                        cyc_stop <= 20'(merge({12'h000, cyc_stop},
                            avs_writedata_i, avs_byteenable_i));
                    end
                    OFS_TRACE_INDEX: begin
                        if (avs_byteenable_i[0]) begin
                            trace_index <= avs_writedata_i[PW-1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Match term registers, two words per term
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int t = 0; t < N_TERMS; t++) begin
                term_lo[t] <= CMP_RESET;
                term_hi[t] <= CMP_RESET;
            end
        end else begin
            for (int t = 0; t < N_TERMS; t++) begin
                if (wr_en && avs_address_i == 8'(OFS_TERM_BASE
                        + 8'(t) * TERM_STRIDE)) begin
                    term_lo[t] <= cmp_s'(20'(merge(32'(term_lo[t]),
                        avs_writedata_i, avs_byteenable_i)));
                end
                if (wr_en && avs_address_i == 8'(OFS_TERM_BASE
                        + 8'(t) * TERM_STRIDE + OFS_TERM_UPPER)) begin
                    term_hi[t] <= cmp_s'(20'(merge(32'(term_hi[t]),
                        avs_writedata_i, avs_byteenable_i)));
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Data comparators
    // ------------------------------------------------------------
    function automatic logic cmp_hit(input cmp_s c, input logic [7:0] d);
        logic raw;
        unique case (c.mode)
            MODE_SINGLE: raw = (d == c.a);
            MODE_RANGE: raw = (d >= c.a) && (d <= c.b);
            MODE_MASK: raw = ((d ^ c.a) & c.b) == 8'h00;
            MODE_OFF: raw = 1'b1;
        endcase
        return raw ^ c.invert;
    endfunction

    logic any_match;
    always_comb begin
        any_match = 1'b0;
        for (int t = 0; t < N_TERMS; t++) begin
            // Upper comparator only counts on a sixteen-bit target
            if (term_lo[t].enable && cmp_hit(term_lo[t], cyc.data[7:0])
                && (!wide_bus || !term_hi[t].enable
                    || cmp_hit(term_hi[t], cyc.data[15:8]))) begin
                any_match = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Capture sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_DELAY,
        ST_DONE
    } cap_state_e;

    cap_state_e state;
    logic [15:0] delay_left;
    logic [PW-1:0] wr_ptr;
    logic buf_full;
    logic trig_evt;
    logic done_evt;
    bus_cycle_s trace_mem [TRACE_DEPTH];
    logic capturing;

    assign capturing = (state == ST_ARMED) || (state == ST_DELAY);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
            delay_left <= '0;
            trig_evt <= 1'b0;
            done_evt <= 1'b0;
        end else begin
            trig_evt <= 1'b0;
            done_evt <= 1'b0;
            if (restart) begin
                state <= ST_ARMED;
            end else if (cyc_pulse) begin
                unique case (state)
                    ST_ARMED: begin
                        if (any_match) begin
                            trig_evt <= 1'b1;
                            delay_left <= delay_cfg;
                            if (delay_cfg == 16'h0000) begin
                                state <= ST_DONE;
                                done_evt <= 1'b1;
                            end else begin
                                state <= ST_DELAY;
                            end
                        end
                    end
                    ST_DELAY: begin
                        // Further matches are not looked at here
                        delay_left <= delay_left - 16'h0001;
                        if (delay_left == 16'h0001) begin
                            state <= ST_DONE;
                            done_evt <= 1'b1;
                        end
                    end
                    ST_IDLE, ST_DONE: begin
                    end
                endcase
            end
        end
    end

    // Circular trace write; oldest entry is overwritten once full
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            buf_full <= 1'b0;
        end else if (restart) begin
            wr_ptr <= '0;
            buf_full <= 1'b0;
        end else if (cyc_pulse && capturing) begin
            if (wr_ptr == LAST_IDX) begin
                wr_ptr <= '0;
                buf_full <= 1'b1;
            end else begin
                wr_ptr <= wr_ptr + 1'b1;
            end
        end
    end

    // Depth 171 = 10 before + trigger + 160 after at the A0 preset
    always_ff @(posedge clk_i) begin
        if (cyc_pulse && capturing) begin
            trace_mem[wr_ptr] <= cyc;
        end
    end

    // Readout index 0 is the oldest stored cycle
    logic [PW:0] rd_sum;
    logic [PW-1:0] rd_phys;
    always_comb begin
        rd_sum = {1'b0, (buf_full ? wr_ptr : {PW{1'b0}})}
                 + {1'b0, trace_index};
        if (rd_sum > {1'b0, LAST_IDX}) begin
            rd_phys = PW'(rd_sum - (PW+1)'(TRACE_DEPTH));
        end else begin
            rd_phys = rd_sum[PW-1:0];
        end
    end

    // ------------------------------------------------------------
    // Bus cycle counter
    // ------------------------------------------------------------
    logic cnt_run;
    logic [31:0] cnt_val;
    logic cnt_evt;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_run <= 1'b0;
            cnt_val <= '0;
            cnt_evt <= 1'b0;
        end else begin
            cnt_evt <= 1'b0;
            if (!cyc_en) begin
                cnt_run <= 1'b0;
            end else if (cyc_pulse) begin
                // Counts reads and writes only, never machine cycles
                if (!cnt_run && cyc.addr == cyc_start) begin
                    cnt_run <= 1'b1;
                    cnt_val <= '0;
                end else if (cnt_run) begin
                    cnt_val <= cnt_val + 32'h0000_0001;
                    if (cyc.addr == cyc_stop) begin
                        cnt_run <= 1'b0;
                        cnt_evt <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] next_irq_status;
    assign irq_set = {cnt_evt, done_evt, trig_evt};
    assign irq_clr = (wr_en && avs_address_i == OFS_IRQ_STATUS
                      && avs_byteenable_i[0])
                     ? avs_writedata_i[IRQ_W-1:0] : '0;
    // Set beats clear so no event is lost
    assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_status <= '0;
            irq_o <= 1'b0;
            trigger_o <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_o <= |(next_irq_status & irq_mask);
            trigger_o <= trig_evt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (avs_address_i)
            OFS_CONTROL: rd_word = {29'h0, cyc_en, wide_bus, 1'b0};
            OFS_STATUS: rd_word = 32'({cnt_run, buf_full, wr_ptr,
                                       2'(state)});
            OFS_DELAY: rd_word = {16'h0000, delay_cfg};
            OFS_IRQ_STATUS: rd_word = 32'(irq_status);
            OFS_IRQ_MASK: rd_word = 32'(irq_mask);
            OFS_CYC_START: rd_word = {12'h000, cyc_start};
            OFS_CYC_STOP: rd_word = {12'h000, cyc_stop};
            OFS_CYC_COUNT: rd_word = cnt_val;
            OFS_TRACE_INDEX: rd_word = 32'(trace_index);
            OFS_TRACE_ADDR: rd_word = {11'h000,
                trace_mem[rd_phys].is_write, trace_mem[rd_phys].addr};
            OFS_TRACE_DATA: rd_word = {16'h0000, trace_mem[rd_phys].data};
            default: begin
                for (int t = 0; t < N_TERMS; t++) begin
                    if (avs_address_i == 8'(OFS_TERM_BASE
                            + 8'(t) * TERM_STRIDE)) begin
                        rd_word = 32'(term_lo[t]);
                    end
                    if (avs_address_i == 8'(OFS_TERM_BASE
                            + 8'(t) * TERM_STRIDE + OFS_TERM_UPPER)) begin
                        rd_word = 32'(term_hi[t]);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_readdata_o <= '0;
        end else if (rd_en) begin
            avs_readdata_o <= rd_word;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/trace_trigger_pkg.sv ====
// Operation
// - Each captured cycle compares data bits 0 to 7 with a programmed byte.
// - Range mode matches data between lower and upper bound, both inclusive.
// - Inversion option makes a term match only outside value or range.
// - Masked mode compares only data bits whose mask bit is one.
// - Several match terms are ORed; any matching term raises trigger.
// - Address and data are latched on every read and write cycle.
// - After trigger, record the programmed cycle count, then stop for readout.
// - Trace buffer is circular; each new cycle overwrites the oldest.
// - Post-trigger delay count register holds values up to FFFF.
// - With delay A0 the buffer keeps ten pre-trigger cycles first.
// - Cycle counter counts bus cycles from start address to stop address.
// - Sixteen-bit targets use a separate comparator for the upper data byte.
package trace_trigger_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_CYC_START = 8'h14;
    localparam logic [7:0] OFS_CYC_STOP = 8'h18;
    localparam logic [7:0] OFS_CYC_COUNT = 8'h1C;
    localparam logic [7:0] OFS_TRACE_INDEX = 8'h20;
    localparam logic [7:0] OFS_TRACE_ADDR = 8'h24;
    localparam logic [7:0] OFS_TRACE_DATA = 8'h28;
    localparam logic [7:0] OFS_TERM_BASE = 8'h40;
    localparam logic [7:0] TERM_STRIDE = 8'h08;
    localparam logic [7:0] OFS_TERM_UPPER = 8'h04;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WIDE_BIT = 1;
    localparam int CTRL_CYC_EN_BIT = 2;
    localparam int IRQ_TRIG_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_CYC_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [15:0] DELAY_RESET = 16'h00A0;
    localparam int TRACE_DEPTH = 171;
    localparam int N_TERMS = 4;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_RANGE,
        MODE_MASK,
        MODE_OFF
    } match_mode_e;

    // One comparator: value/lower/pattern in a, upper/mask in b
    typedef struct packed {
        logic enable;
        logic invert;
        match_mode_e mode;
        logic [7:0] b;
        logic [7:0] a;
    } cmp_s;

    localparam cmp_s CMP_RESET = '{1'b0, 1'b0, MODE_SINGLE, 8'h00, 8'h00};

    typedef struct packed {
        logic is_write;
        logic [19:0] addr;
        logic [15:0] data;
    } bus_cycle_s;

endpackage

// ==== verif/trace_trigger_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module trace_trigger_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Watched ports
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic tgt_rd_n_i,
    input wire logic tgt_wr_n_i,
    input wire logic irq_o,
    input wire logic trigger_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ------
    // Cycles since the last strobe release
    // ------
    logic strobe_q;
    logic [3:0] since_rise;
    wire logic bus_idle = tgt_rd_n_i & tgt_wr_n_i;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strobe_q <= 1'b1;
            since_rise <= 4'hF;
        end else begin
            strobe_q <= bus_idle;
            if (bus_idle && !strobe_q) begin
                since_rise <= 4'h0;
            end else if (since_rise != 4'hF) begin
                since_rise <= since_rise + 4'h1;
            end
        end
    end

    // ------
    // Properties
    // ------
    property p_wait_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    property p_wait_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_answer: assert property (p_wait_answer)
        else $error("request not answered after one cycle");
    property p_wait_idle;
        !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
    endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("waitrequest low without request");
    property p_rd_hold;
        $changed(avs_readdata_o) |-> $past(avs_read_i);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");
    property p_trig_pulse;
        trigger_o |=> !trigger_o [*6];
    endproperty
    a_trig_pulse: assert property (p_trig_pulse)
        else $error("trigger pulse too long or repeated too soon");
    property p_trig_cause;
        trigger_o |-> since_rise inside {[4'h1:4'h9]};
    endproperty
    a_trig_cause: assert property (p_trig_cause)
        else $error("trigger without a finished bus cycle");
    property p_irq_rise;
        $rose(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2)
            || since_rise < 4'hC;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt rose without cause");
    property p_irq_fall;
        $fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a write");
    c_trig: cover property (trigger_o);
    c_irq: cover property (irq_o);
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind trace_trigger trace_trigger_monitor u_mon (
    .clk_i, .arst_n_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
    .avs_waitrequest_o, .tgt_rd_n_i, .tgt_wr_n_i, .irq_o, .trigger_o
);
`default_nettype wire

// ==== verif/tgt_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tgt_bus_model (
    // Clock and command
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [19:0] addr_i,
    input wire logic [15:0] data_i,
    input wire logic wr_i,
    output logic busy_o,
    // Target bus pins
    output logic [19:0] tgt_addr_o,
    output logic [15:0] tgt_data_o,
    output logic tgt_rd_n_o,
    output logic tgt_wr_n_o
);
    logic [3:0] cnt = 4'h0;
    initial begin
        busy_o = 1'b0;
        tgt_rd_n_o = 1'b1;
        tgt_wr_n_o = 1'b1;
        tgt_addr_o = 20'h00000;
        tgt_data_o = 16'h0000;
    end
    // Strobe low four clocks, then high at least nine before the next cycle
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt <= 4'h0;
            tgt_addr_o <= addr_i;
            tgt_data_o <= data_i;
            tgt_rd_n_o <= wr_i;
            tgt_wr_n_o <= !wr_i;
        end else if (busy_o) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h3) begin
                // Released lines show stale garbage, never the held value
                tgt_rd_n_o <= 1'b1;
                tgt_wr_n_o <= 1'b1;
                tgt_addr_o <= ~tgt_addr_o;
                tgt_data_o <= ~tgt_data_o;
            end
            if (cnt == 4'hB) begin
                busy_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import trace_trigger_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic avs_waitrequest_o, irq_o, trigger_o, tgt_rd_n_i, tgt_wr_n_i;
    logic [19:0] tgt_addr_i, go_addr = 20'h0;
    logic [15:0] tgt_data_i, go_data = 16'h0;
    logic go = 1'b0, go_wr = 1'b0, busy;
    int mismatches = 0, samples_checked = 0, trig_cnt = 0;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (trigger_o === 1'b1) trig_cnt++;
    end
    trace_trigger u_trace_trigger (.clk_i, .arst_n_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_byteenable_i(4'hF), .avs_writedata_i,
        .avs_readdata_o, .avs_waitrequest_o, .tgt_addr_i, .tgt_data_i,
        .tgt_rd_n_i, .tgt_wr_n_i, .irq_o, .trigger_o);
    tgt_bus_model u_tgt_bus_model (.clk_i, .go_i(go), .addr_i(go_addr),
        .data_i(go_data), .wr_i(go_wr), .busy_o(busy), .tgt_addr_o(tgt_addr_i),
        .tgt_data_o(tgt_data_i), .tgt_rd_n_o(tgt_rd_n_i),
        .tgt_wr_n_o(tgt_wr_n_i));
    // ------
    // Shared tasks
    // ------
    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic guard(input logic ok);
        if (!ok) begin
            chk(32'h1, 32'h0);
            wrap_up();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        guard(avs_waitrequest_o === 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic tcyc(input logic [19:0] a, input logic [15:0] d,
                        input logic w);
        int n;
        n = 0;
        @(posedge clk_i);
        go_addr <= a;
        go_data <= d;
        go_wr <= w;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 40);
        guard(busy === 1'b0);
    endtask
    // ------
    // Scenarios
    // ------
    task automatic s_regs();
        logic [31:0] p[4] = '{32'hA0, 32'h55, 32'h4, 32'hAA};
        rd(OFS_DELAY, 32'hA0);
        wr(8'h3C, 32'h5);
        rd(8'h3C, 32'h0);
        wr(OFS_DELAY, 32'h1_FFFF);
        rd(OFS_DELAY, 32'hFFFF);
        foreach (p[k]) begin
            wr(OFS_DELAY, p[k]);
            rd(OFS_DELAY, p[k]);
        end
    endtask
    task automatic s_trace();
        int ix[3] = '{0, 10, 170};
        logic [31:0] ea[3] = '{32'h0010_000A, 32'h14, 32'hB4};
        logic [31:0] ed[3] = '{32'h11, 32'h5A, 32'h11};
        int t0;
        wr(OFS_TERM_BASE, 32'h8_005A);
        wr(OFS_DELAY, 32'hA0);
        wr(OFS_CONTROL, 32'h1);
        t0 = trig_cnt;
        for (int n = 0; n < 200; n++) begin
            tcyc(20'(n), (n == 20 || n == 40) ? 16'h5A : 16'h11, n[1]);
        end
        chk(32'(trig_cnt - t0), 32'h1);
        foreach (ix[k]) begin
            wr(OFS_TRACE_INDEX, 32'(ix[k]));
            rd(OFS_TRACE_ADDR, ea[k]);
            rd(OFS_TRACE_DATA, ed[k]);
        end
    endtask
    task automatic s_compare();
        logic [31:0] lo[12] = '{32'h8_0023, 32'h8_0023, 32'h9_3412,
            32'h9_3412, 32'h9_3412, 32'hD_3412, 32'hD_3412, 32'hA_F030,
            32'hA_F030, 32'h8_0023, 32'hB_0000, 32'hB_0000};
        logic [15:0] dt[12] = '{16'h23, 16'hFF23, 16'h12, 16'h34, 16'h35,
            16'h35, 16'h20, 16'h3F, 16'h4F, 16'h45, 16'hAB77, 16'hAC77};
        logic [11:0] hit = 12'h6AF;
        wr(OFS_DELAY, 32'h0);
        for (int i = 0; i < 12; i++) begin
            wr(OFS_TERM_BASE, lo[i]);
            wr(OFS_TERM_BASE + TERM_STRIDE, (i == 9) ? 32'h8_0045 : 32'h0);
            wr(OFS_TERM_BASE + OFS_TERM_UPPER, (i > 9) ? 32'h8_00AB : 32'h0);
            wr(OFS_CONTROL, (i > 9) ? 32'h3 : 32'h1);
            tcyc(20'h00123, dt[i], 1'b0);
            rd(OFS_IRQ_STATUS, hit[i] ? 32'h3 : 32'h0);
            wr(OFS_IRQ_STATUS, 32'h7);
        end
    endtask
    task automatic s_count();
        logic [19:0] ca[6] = '{20'h50, 20'h100, 20'h101, 20'h102, 20'h105,
            20'h106};
        wr(OFS_TERM_BASE, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_CYC_START, 32'h100);
        wr(OFS_CYC_STOP, 32'h105);
        wr(OFS_CONTROL, 32'h4);
        foreach (ca[k]) begin
            tcyc(ca[k], 16'h0, k == 3);
        end
        rd(OFS_CYC_COUNT, 32'h3);
        rd(OFS_IRQ_STATUS, 32'h4);
        chk(32'(irq_o), 32'h0);
        wr(OFS_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        wr(OFS_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        rd(OFS_IRQ_STATUS, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        s_regs();
        s_trace();
        s_compare();
        s_count();
        wrap_up();
    end
endmodule
`default_nettype wire
